// File: xy_link_pkg.sv
package xy_link_pkg;
	localparam int unsigned MCLK_HZ        = 10_000_000;
	localparam int unsigned LINK_HZ        = 2_000_000;
	localparam int unsigned LINK_DIV       = MCLK_HZ / LINK_HZ;
	localparam int unsigned LINK_HIGH      = LINK_DIV / 2;
	localparam logic [2:0]  PH_LAST        = 3'(LINK_DIV - 1);
	localparam logic [2:0]  PH_FALL        = 3'(LINK_HIGH - 1);
	localparam logic [2:0]  PH_SAMPLE      = 3'(LINK_DIV - 1);
	localparam int unsigned WORD_BITS      = 20;
	localparam logic [4:0]  SLOT_LAST      = 5'(WORD_BITS - 1);
	localparam logic [4:0]  SLOT_SYNC      = 5'(WORD_BITS - 1);
	localparam logic [2:0]  CODE_POS16     = 3'h1;
	localparam logic [2:0]  CODE_STAT_2AX  = 3'h3;
	localparam logic [2:0]  CODE_STAT_3AX  = 3'h1;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_POS_X      = 8'h04;
	localparam logic [7:0]  OFS_POS_Y      = 8'h08;
	localparam logic [7:0]  OFS_POS_Z      = 8'h0c;
	localparam logic [7:0]  OFS_STATUS     = 8'h10;
	localparam logic [7:0]  OFS_INT_STAT   = 8'h14;
	localparam logic [7:0]  OFS_INT_MASK   = 8'h18;
	localparam int unsigned CTRL_3AX_BIT   = 0;
	localparam logic [15:0] POS_RESET      = 16'h8000;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam int unsigned INT_FRAME_BIT  = 0;
	localparam int unsigned INT_RX_BIT     = 1;
	localparam int unsigned INT_PAR_BIT    = 2;
	localparam int unsigned INT_CODE_BIT   = 3;
	localparam int unsigned INT_BITS       = 4;
	localparam int unsigned STAT_PERR_BIT  = 20;
endpackage : xy_link_pkg

// File: sync_2ff.sv
`timescale 1ns/1ns
module sync_2ff (
	input  wire logic mclk,
	input  wire logic rst_sync_b,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_reg;

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : sync_2ff

// File: galvo_position_serial_link.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
//Contract
// - link clock runs continuously at 2 MHz, twenty clock cycles per frame
// - receiver samples sync and data on falling edge; lines stay stable there
// - one sync pulse per frame, low one cycle, just before the first bit
// - three position words on X, Y, Z lines in parallel, status on its own line
// - each position word: 3-bit code, 16-bit position MSB first, even parity
// - generator always sends code 001; other codes are reserved
// - status stream is code, 16-bit word, parity; latched on falling edge
// - 2-axis status uses code 011 without parity; controller makes even parity
// - 3-axis status uses code 001 with even parity and per-axis flag groups
module galvo_position_serial_link (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             link_clk,
	output logic             link_sync,
	output logic             x_data,
	output logic             y_data,
	output logic             z_data,
	input  wire logic        status_in
);
	localparam int unsigned INT_BITS_W = xy_link_pkg::INT_BITS;

	logic        rst_meta_reg;
	logic        rst_sync_b;
	logic [2:0]  phase_reg;
	logic [4:0]  slot_reg;
	logic [15:0] pos_reg [3];
	logic [19:0] shift_reg [3];
	logic [19:0] load_word [3];
	logic [31:0] ctrl_reg;
	logic [19:0] rx_shift_reg;
	logic [20:0] status_reg;
	logic [INT_BITS_W-1:0] int_stat_reg;
	logic [INT_BITS_W-1:0] int_mask_reg;
	logic [INT_BITS_W-1:0] int_event;
	logic        status_sync;
	logic        rise_now;
	logic        fall_now;
	logic        sample_now;
	logic        frame_end;
	logic        wr_en;
	logic        rd_en;
	logic [19:0] rx_word;
	logic [2:0]  rx_code;
	logic        rx_perr;
	logic        rx_cerr;
	logic        rx_par_used;

	function automatic logic even_par(input logic [18:0] bits);
		even_par = ^bits;
	endfunction : even_par

	function automatic logic [19:0] pos_word(input logic [15:0] pos);
		pos_word = {xy_link_pkg::CODE_POS16, pos,
			even_par({xy_link_pkg::CODE_POS16, pos})};
	endfunction : pos_word

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == xy_link_pkg::OFS_CTRL) || (a == xy_link_pkg::OFS_POS_X)
			|| (a == xy_link_pkg::OFS_POS_Y) || (a == xy_link_pkg::OFS_POS_Z)
			|| (a == xy_link_pkg::OFS_STATUS) || (a == xy_link_pkg::OFS_INT_STAT)
			|| (a == xy_link_pkg::OFS_INT_MASK);
	endfunction : addr_hit

	function automatic logic [31:0] rd_value(input logic [7:0] a);
		unique case (a)
			xy_link_pkg::OFS_CTRL:     rd_value = ctrl_reg;
			xy_link_pkg::OFS_POS_X:    rd_value = {16'h0000, pos_reg[0]};
			xy_link_pkg::OFS_POS_Y:    rd_value = {16'h0000, pos_reg[1]};
			xy_link_pkg::OFS_POS_Z:    rd_value = {16'h0000, pos_reg[2]};
			xy_link_pkg::OFS_STATUS:   rd_value = {11'h000, status_reg};
			xy_link_pkg::OFS_INT_STAT: rd_value = {28'h0000000, int_stat_reg};
			xy_link_pkg::OFS_INT_MASK: rd_value = {28'h0000000, int_mask_reg};
			default:                   rd_value = 32'h0000_0000;
		endcase
	endfunction : rd_value

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b   <= rst_meta_reg;
		end
	end

	sync_2ff status_sync_i (
		.mclk       (mclk),
		.rst_sync_b (rst_sync_b),
		.async_in   (status_in),
		.sync_out   (status_sync)
	);

	// link clock divider
	assign rise_now   = (phase_reg == xy_link_pkg::PH_LAST);
	assign fall_now   = (phase_reg == xy_link_pkg::PH_FALL);
	assign sample_now = (phase_reg == xy_link_pkg::PH_SAMPLE);
	assign frame_end  = sample_now && (slot_reg == xy_link_pkg::SLOT_LAST);

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			phase_reg <= 3'h0;
		end else if (rise_now) begin
			phase_reg <= 3'h0;
		end else begin
			phase_reg <= phase_reg + 3'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			link_clk <= 1'b0;
		end else if (rise_now) begin
			link_clk <= 1'b1;
		end else if (fall_now) begin
			link_clk <= 1'b0;
		end
	end

	// slot counter, twenty per frame
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			slot_reg <= xy_link_pkg::SLOT_LAST;
		end else if (rise_now) begin
			slot_reg <= (slot_reg == xy_link_pkg::SLOT_LAST) ? 5'h00 : slot_reg + 5'h01;
		end
	end

	// sync low during the slot before bit one
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			link_sync <= 1'b1;
		end else if (rise_now) begin
			link_sync <= (slot_reg != xy_link_pkg::SLOT_SYNC - 5'h01);
		end
	end

	// position shifters, one per axis
	for (genvar g = 0; g < 3; g++) begin : g_axis
		assign load_word[g] = pos_word(pos_reg[g]);

		always_ff @(posedge mclk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				shift_reg[g] <= 20'h00000;
			end else if (rise_now) begin
				if (slot_reg == xy_link_pkg::SLOT_LAST) begin
					shift_reg[g] <= load_word[g];
				end else begin
					shift_reg[g] <= {shift_reg[g][18:0], 1'b0};
				end
			end
		end
	end

	// data lines update only on the rising edge
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			x_data <= 1'b0;
		end else if (rise_now) begin
			if (slot_reg == xy_link_pkg::SLOT_LAST) begin
				x_data <= load_word[0][19];
			end else begin
				x_data <= shift_reg[0][18];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			y_data <= 1'b0;
		end else if (rise_now) begin
			if (slot_reg == xy_link_pkg::SLOT_LAST) begin
				y_data <= load_word[1][19];
			end else begin
				y_data <= shift_reg[1][18];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			z_data <= 1'b0;
		end else if (rise_now) begin
			if (slot_reg == xy_link_pkg::SLOT_LAST) begin
				z_data <= load_word[2][19];
			end else begin
				z_data <= shift_reg[2][18];
			end
		end
	end

	// status capture at the rising-edge phase, taking the bit that stood at the falling edge after synchroniser delay
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rx_shift_reg <= 20'h00000;
		end else if (sample_now) begin
			rx_shift_reg <= {rx_shift_reg[18:0], status_sync};
		end
	end

	assign rx_word     = {rx_shift_reg[18:0], status_sync};
	assign rx_code     = rx_word[19:17];
	assign rx_par_used = ctrl_reg[xy_link_pkg::CTRL_3AX_BIT];
	assign rx_cerr     = rx_par_used ? (rx_code != xy_link_pkg::CODE_STAT_3AX)
		: (rx_code != xy_link_pkg::CODE_STAT_2AX);
	assign rx_perr     = rx_par_used && (even_par(rx_word[19:1]) != rx_word[0]);

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			status_reg <= 21'h000000;
		end else if (frame_end) begin
			// 2-axis word carries no parity; controller supplies it
			status_reg <= {rx_perr, rx_word[19:1],
				rx_par_used ? rx_word[0] : even_par(rx_word[19:1])};
		end
	end

	// apb slave
	assign wr_en = psel && penable && pready && pwrite && addr_hit(paddr);
	assign rd_en = psel && penable && !pready;

	// ready one cycle after the first access cycle
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pready <= 1'b0;
		end else begin
			pready <= rd_en;
		end
	end

	// error only for unmapped offsets
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= rd_en && !addr_hit(paddr);
		end
	end

	// read data stands only with pready
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !pwrite) begin
			prdata <= rd_value(paddr);
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_reg <= xy_link_pkg::CTRL_RESET;
		end else if (wr_en && paddr == xy_link_pkg::OFS_CTRL) begin
			ctrl_reg <= {31'h00000000, pwdata[xy_link_pkg::CTRL_3AX_BIT]};
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pos_reg[0] <= xy_link_pkg::POS_RESET;
			pos_reg[1] <= xy_link_pkg::POS_RESET;
			pos_reg[2] <= xy_link_pkg::POS_RESET;
		end else if (wr_en) begin
			if (paddr == xy_link_pkg::OFS_POS_X) pos_reg[0] <= pwdata[15:0];
			if (paddr == xy_link_pkg::OFS_POS_Y) pos_reg[1] <= pwdata[15:0];
			if (paddr == xy_link_pkg::OFS_POS_Z) pos_reg[2] <= pwdata[15:0];
		end
	end

	// interrupts; a new event beats a write-one clear
	assign int_event = {frame_end && rx_cerr, frame_end && rx_perr, frame_end, frame_end};

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			int_stat_reg <= 4'h0;
		end else if (wr_en && paddr == xy_link_pkg::OFS_INT_STAT) begin
			int_stat_reg <= (int_stat_reg & ~pwdata[3:0]) | int_event;
		end else begin
			int_stat_reg <= int_stat_reg | int_event;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			int_mask_reg <= 4'h0;
		end else if (wr_en && paddr == xy_link_pkg::OFS_INT_MASK) begin
			int_mask_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end
endmodule : galvo_position_serial_link

// File: galvo_link_properties.sv
`timescale 1ns/1ns
module galvo_link_checker (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        link_clk,
	input wire logic        link_sync,
	input wire logic        x_data,
	input wire logic        y_data,
	input wire logic        z_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	clk_shape_a: assert property ($rose(link_clk) |=> link_clk ##1 !link_clk[*3] ##1 link_clk)
		else $error("link clock shape wrong");
	frame_len_a: assert property ($fell(link_sync) |-> ##100 $fell(link_sync))
		else $error("frame length wrong");
	sync_pulse_a: assert property ($fell(link_sync) |=> !link_sync[*4] ##1 link_sync)
		else $error("sync pulse width wrong");
	code_bits_a: assert property ($rose(link_sync) |-> !(x_data | y_data | z_data) ##5
		!(x_data | y_data | z_data) ##5 (x_data & y_data & z_data))
		else $error("control code wrong");
	edge_only_a: assert property (!$rose(link_clk) |-> $stable({link_sync, x_data, y_data, z_data}))
		else $error("link output changed off rising edge");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("pready without access phase");
	err_only_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero when idle");
	unmapped_a: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access without error");
	cover property ($fell(link_sync));
	cover property (pslverr);
	cover property ($rose(irq));
endmodule : galvo_link_checker

bind galvo_position_serial_link galvo_link_checker chk_i (.mclk, .rst_b, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .irq, .link_clk, .link_sync, .x_data, .y_data, .z_data);

// File: scan_head_model.sv
`timescale 1ns/1ns
module scan_head_model (
	input  wire logic        link_clk,
	input  wire logic        link_sync,
	input  wire logic        x_data,
	input  wire logic        y_data,
	input  wire logic        z_data,
	input  wire logic [19:0] stat_word,
	output logic             status_in,
	output logic      [15:0] x_pos,
	output logic      [15:0] y_pos,
	output logic      [15:0] z_pos
);
	logic [19:0] x_sh, y_sh, z_sh, out_sh;
	logic [4:0]  cnt;
	logic        frame_end;
	initial begin
		{x_pos, y_pos, z_pos, cnt, frame_end, status_in, out_sh} = '0;
	end
	function automatic logic ok(input logic [19:0] w);
		return w[19:17] == 3'h1 && ^w == 1'b0;
	endfunction : ok
	always @(negedge link_clk) begin
		x_sh = {x_sh[18:0], x_data};
		y_sh = {y_sh[18:0], y_data};
		z_sh = {z_sh[18:0], z_data};
		frame_end = !link_sync;
		if (frame_end && cnt == 5'd19) begin
			if (ok(x_sh)) x_pos = x_sh[16:1];
			if (ok(y_sh)) y_pos = y_sh[16:1];
			if (ok(z_sh)) z_pos = z_sh[16:1];
		end
		cnt = frame_end ? 5'd0 : cnt + 5'd1;
	end
	always @(posedge link_clk) begin
		if (frame_end) out_sh = stat_word;
		status_in = out_sh[19];
		out_sh = out_sh << 1;
	end
endmodule : scan_head_model

// File: test_galvo_position_serial_link.sv
`timescale 1ns/1ns
module test_galvo_position_serial_link;
	logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq, e;
	logic        link_clk, link_sync, x_data, y_data, z_data, status_in;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [19:0] stat_word;
	logic [15:0] x_pos, y_pos, z_pos;
	int          fails, compares;
	galvo_position_serial_link uut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .link_clk, .link_sync, .x_data, .y_data, .z_data,
		.status_in);
	scan_head_model head (.link_clk, .link_sync, .x_data, .y_data, .z_data, .stat_word,
		.status_in, .x_pos, .y_pos, .z_pos);
	always #50 mclk = ~mclk;
	task complete_run;
		if (fails == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			complete_run();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task frames(input int n);
		repeat (n * 100) @(posedge mclk);
	endtask : frames
	task irq_is(input logic x);
		repeat (3) @(posedge mclk);
		chk("irq", {31'h0, x}, {31'h0, irq});
	endtask : irq_is
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		complete_run();
	end
	initial begin
		{mclk, rst_b, psel, penable, pwrite, paddr, pwdata, fails, compares} = '0;
		stat_word = {3'h3, 16'hf5f5, 1'b1};
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		frames(3);
		chk("x reset", 32'h8000, {16'h0, x_pos});
		apb(0, 8'h00, 0);
		chk("ctrl", 32'h0, q);
		apb(0, 8'h1c, 0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1, 8'h04, 32'h1234);
		apb(1, 8'h08, 32'hffff);
		apb(1, 8'h0c, 32'h0);
		apb(0, 8'h04, 0);
		chk("pos x reg", 32'h1234, q);
		frames(3);
		chk("x pos", 32'h1234, {16'h0, x_pos});
		chk("y pos", 32'hffff, {16'h0, y_pos});
		chk("z pos", 32'h0, {16'h0, z_pos});
		apb(1, 8'h14, 32'hf);
		frames(2);
		apb(0, 8'h14, 0);
		chk("int 2ax", 32'h3, q & 32'hf);
		apb(0, 8'h10, 0);
		chk("status 2ax", 32'h0007ebea, q);
		stat_word <= {3'h1, 16'hcae4, 1'b0};
		apb(1, 8'h00, 32'h1);
		frames(1);
		apb(1, 8'h14, 32'hf);
		frames(2);
		apb(0, 8'h10, 0);
		chk("status bad par", 32'h001395c8, q);
		apb(0, 8'h14, 0);
		chk("int par", 32'h4, q & 32'hc);
		apb(1, 8'h18, 32'h4);
		irq_is(1'b1);
		apb(1, 8'h18, 32'h8);
		irq_is(1'b0);
		stat_word <= {3'h1, 16'hcae4, 1'b1};
		apb(1, 8'h00, 32'h0);
		apb(1, 8'h14, 32'hf);
		frames(3);
		apb(0, 8'h14, 0);
		chk("int code", 32'h8, q & 32'hc);
		irq_is(1'b1);
		apb(1, 8'h00, 32'h1);
		frames(2);
		apb(1, 8'h14, 32'hf);
		irq_is(1'b0);
		apb(0, 8'h14, 0);
		chk("int clear", 32'h0, q & 32'hc);
		apb(0, 8'h10, 0);
		chk("status good", 32'h000395c9, q);
		complete_run();
	end
endmodule : test_galvo_position_serial_link
